// File: core/mhc_csr_map.svh
// register offsets, field positions, reset values and timing figures of the misc host csr bank
`ifndef MHC_CSR_MAP_SVH
`define MHC_CSR_MAP_SVH
`define MHC_OFS_TIMER_COUNT   8'h90
`define MHC_OFS_HALF_ORDER    8'h98
`define MHC_OFS_FREE_RUN      8'h9C
`define MHC_OFS_DROP_COUNT    8'hA0
`define MHC_OFS_IND_CMD       8'hA4
`define MHC_OFS_IND_DATA      8'hA8
`define MHC_OFS_IRQ_STATUS    8'hC0
`define MHC_OFS_IRQ_MASK      8'hC4
`define MHC_OFS_FREE_RUN_HELD 8'hC8
`define MHC_RST_TIMER_COUNT   16'hFFFF
`define MHC_RST_ZERO32        32'h0000_0000
`define MHC_SWAP_PATTERN      32'hFFFF_FFFF
`define MHC_DROP_MIDPOINT     32'h8000_0000
`define MHC_CMD_BUSY_BIT      31
`define MHC_CMD_DIR_BIT       30
`define MHC_CMD_ADDR_MSB      7
`define MHC_IRQ_DROP_MID_BIT  0
`define MHC_IRQ_IND_DONE_BIT  1
`define MHC_IRQ_WIDTH         2
`define MHC_SYS_CLK_MHZ       125
`define MHC_FREE_RUN_MHZ      25
`define MHC_FR_DIV            (`MHC_SYS_CLK_MHZ / `MHC_FREE_RUN_MHZ)
`define MHC_FR_CLEAR_NS       160
`define MHC_FR_CLEAR_CYC      ((`MHC_FR_CLEAR_NS * `MHC_SYS_CLK_MHZ) / 1000)
`endif

// File: core/mhc_pkg.sv
// types shared by the misc host csr bank and its neighbours
package mhc_pkg;
    // request toward the internal mac register file
    typedef struct packed {
        logic        valid;
        logic        read;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } mhc_mac_req_t;

    // answer from the internal mac register file
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } mhc_mac_rsp_t;

    // one-hot states of the indirect window
    typedef enum logic [1:0] {
        MHC_IND_IDLE = 2'b01,
        MHC_IND_BUSY = 2'b10
    } mhc_ind_state_t;
endpackage

// File: core/mhc_csr_bank.sv
// misc host csr bank: timer view, halfword order, free-run counter, drop counter, indirect mac window
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "mhc_csr_map.svh"

module mhc_csr_bank #(
    parameter int FR_WIDTH = 32
) (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    input  wire logic [15:0]           gpTimerCount,
    input  wire logic                  softReset,
    input  wire logic [1:0]            powerState,
    input  wire logic                  hostAddrBit1,
    output logic                       hostUpperSel,
    input  wire logic                  rxFrameDrop,
    input  wire logic                  txWordValid,
    input  wire logic [31:0]           txWord,
    output logic                       txWordReady,
    output logic                       txHalfValid,
    output logic [15:0]                txHalf,
    input  wire logic                  rxHalfValid,
    input  wire logic [15:0]           rxHalf,
    output logic                       rxWordValid,
    output logic [31:0]                rxWord,
    output mhc_pkg::mhc_mac_req_t      macReq,
    input  wire mhc_pkg::mhc_mac_rsp_t macRsp,
    output logic                       irq
);
    import mhc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // registers
    logic [15:0]                timerCount_r, txHalf_r, rxLow_r;
    logic [31:0]                halfOrder_r, dropCount_r, dropCount_nxt, indData_r, prdata_r, txHold_r, rxWord_r;
    logic [FR_WIDTH-1:0]        freeRun_r, freeRunHeld_r;
    logic [2:0]                 divCount_r;
    logic [7:0]                 cmdAddr_r;
    logic [`MHC_IRQ_WIDTH-1:0]  irqStatus_r, irqMask_r, irqSet;
    mhc_ind_state_t             indState_r;
    logic                       frTick, dropMidEvent, cmdDir_r, pslverr_r;
    logic                       txHalfValid_r, txSecond_r, rxHaveLow_r, rxWordValid_r;
    logic                       setupPhase, accessDone, wrDone, rdDone, indBusy, indDone;

    // merge write data into a register under byte strobes
    function automatic logic [31:0] strobeMerge(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                res[i*8 +: 8] = wd[i*8 +: 8];
        return res;
    endfunction
    // true when the offset belongs to this bank
    function automatic logic isMapped(input logic [7:0] a);
        return (a == `MHC_OFS_TIMER_COUNT) || (a == `MHC_OFS_HALF_ORDER) || (a == `MHC_OFS_FREE_RUN) ||
               (a == `MHC_OFS_DROP_COUNT) || (a == `MHC_OFS_IND_CMD) || (a == `MHC_OFS_IND_DATA) ||
               (a == `MHC_OFS_IRQ_STATUS) || (a == `MHC_OFS_IRQ_MASK) || (a == `MHC_OFS_FREE_RUN_HELD);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // apb slave: read data is latched in the setup cycle so prdata comes from a flop
    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable;
    assign wrDone     = accessDone && pwrite && isMapped(paddr);
    assign rdDone     = accessDone && !pwrite;
    assign pready     = 1'b1;
    assign prdata     = prdata_r;
    assign pslverr    = pslverr_r && accessDone;
    assign indBusy    = (indState_r == MHC_IND_BUSY);

    // read mux, sampled in the setup cycle
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata_r  <= `MHC_RST_ZERO32;
            pslverr_r <= 1'b0;
        end
        else if (setupPhase)
        begin
            pslverr_r <= !isMapped(paddr);
            prdata_r  <= `MHC_RST_ZERO32;          // reserved and write cycles read zero
            if (!pwrite)
            begin
                case (paddr)
                    `MHC_OFS_TIMER_COUNT:   prdata_r <= {16'h0000, timerCount_r};
                    `MHC_OFS_HALF_ORDER:    prdata_r <= halfOrder_r;
                    `MHC_OFS_FREE_RUN:      prdata_r <= 32'(freeRun_r);
                    `MHC_OFS_FREE_RUN_HELD: prdata_r <= 32'(freeRunHeld_r);
                    `MHC_OFS_DROP_COUNT:    prdata_r <= dropCount_r;
                    `MHC_OFS_IND_CMD:       prdata_r <= {indBusy, cmdDir_r, 22'h000000, cmdAddr_r};
                    `MHC_OFS_IND_DATA:      prdata_r <= indData_r;
                    `MHC_OFS_IRQ_STATUS:    prdata_r <= {30'h00000000, irqStatus_r};
                    `MHC_OFS_IRQ_MASK:      prdata_r <= {30'h00000000, irqMask_r};
                    default:                prdata_r <= `MHC_RST_ZERO32;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // timer view and halfword order
    // live copy of the general timer count
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            timerCount_r <= `MHC_RST_TIMER_COUNT;
        else
            timerCount_r <= gpTimerCount;
    end
    // halfword order word; kept across soft reset, only the pin reset clears it
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            halfOrder_r <= `MHC_RST_ZERO32;
        else if (wrDone && paddr == `MHC_OFS_HALF_ORDER)
            halfOrder_r <= strobeMerge(halfOrder_r, pwdata, pstrb);
    end

    // only the exact all-ones pattern swaps; any other value keeps the natural order
    assign hostUpperSel = (halfOrder_r == `MHC_SWAP_PATTERN) ? !hostAddrBit1 : hostAddrBit1;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // network halfword order: lower half always first, independent of the host order
    assign txWordReady = !txHalfValid_r;
    assign txHalfValid = txHalfValid_r;
    assign txHalf      = txHalf_r;

    // split a transmit word into two halves, lower first
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            txHold_r      <= `MHC_RST_ZERO32;
            txHalfValid_r <= 1'b0;
            txSecond_r    <= 1'b0;
            txHalf_r      <= 16'h0000;
        end
        else if (txWordValid && txWordReady)
        begin
            txHold_r      <= txWord;
            txHalf_r      <= txWord[15:0];
            txHalfValid_r <= 1'b1;
            txSecond_r    <= 1'b0;
        end
        else if (txHalfValid_r && !txSecond_r)
        begin
            txHalf_r   <= txHold_r[31:16];
            txSecond_r <= 1'b1;
        end
        else
        begin
            txHalfValid_r <= 1'b0;
            txSecond_r    <= 1'b0;
        end
    end

    assign rxWordValid = rxWordValid_r;
    assign rxWord      = rxWord_r;
    // first received half goes to the lower half of the fifo word
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rxHaveLow_r   <= 1'b0;
            rxLow_r       <= 16'h0000;
            rxWord_r      <= `MHC_RST_ZERO32;
            rxWordValid_r <= 1'b0;
        end
        else
        begin
            rxWordValid_r <= 1'b0;
            if (rxHalfValid)
            begin
                if (!rxHaveLow_r)
                begin
                    rxLow_r     <= rxHalf;
                    rxHaveLow_r <= 1'b1;
                end
                else
                begin
                    rxWord_r      <= {rxHalf, rxLow_r};
                    rxWordValid_r <= 1'b1;
                    rxHaveLow_r   <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // free-running counter on a 25MHz enable; power state deliberately not looked at
    // divide the system clock down to one tick per 25MHz cycle
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            divCount_r <= 3'h0;
        else if (softReset || divCount_r == 3'(`MHC_FR_DIV - 1))
            divCount_r <= 3'h0;
        else
            divCount_r <= divCount_r + 3'h1;
    end
    assign frTick = (divCount_r == 3'(`MHC_FR_DIV - 1));
    // soft reset clears on the next edge, well inside the allowed clearing time
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            freeRun_r <= '0;
        else if (softReset)
            freeRun_r <= '0;
        else if (frTick)
            freeRun_r <= freeRun_r + 1'b1;
    end
    // snapshot taken with the first read, the second halfword comes from here
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            freeRunHeld_r <= '0;
        else if (setupPhase && !pwrite && paddr == `MHC_OFS_FREE_RUN)
            freeRunHeld_r <= freeRun_r;
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // dropped frame counter, clear on read; the value read was taken at the setup edge, so only that
    // much is removed and a drop counted on that edge is kept; a drop in the clearing cycle counts as one
    always_comb
    begin
        dropCount_nxt = dropCount_r;
        if (rdDone && paddr == `MHC_OFS_DROP_COUNT)
            dropCount_nxt = dropCount_r - prdata_r;
        if (rxFrameDrop)
            dropCount_nxt = dropCount_nxt + 32'h0000_0001;
    end
    assign dropMidEvent = rxFrameDrop && (dropCount_nxt == `MHC_DROP_MIDPOINT)
                          && (dropCount_r != `MHC_DROP_MIDPOINT);
    // drop counter state
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            dropCount_r <= `MHC_RST_ZERO32;
        else
            dropCount_r <= dropCount_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // indirect window to the mac register file; writes while busy are dropped to protect the access
    // command fields
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cmdDir_r  <= 1'b0;
            cmdAddr_r <= 8'h00;
        end
        else if (wrDone && paddr == `MHC_OFS_IND_CMD && !indBusy)
        begin
            if (pstrb[3])
                cmdDir_r <= pwdata[`MHC_CMD_DIR_BIT];
            if (pstrb[0])
                cmdAddr_r <= pwdata[`MHC_CMD_ADDR_MSB:0];
        end
    end
    // busy state: set by the host, cleared by the mac answer
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            indState_r <= MHC_IND_IDLE;
        else
        begin
            case (indState_r)
                MHC_IND_IDLE:
                    if (wrDone && paddr == `MHC_OFS_IND_CMD && pstrb[3] && pwdata[`MHC_CMD_BUSY_BIT])
                        indState_r <= MHC_IND_BUSY;
                MHC_IND_BUSY:
                    if (macRsp.ack)
                        indState_r <= MHC_IND_IDLE;
                default:
                    indState_r <= MHC_IND_IDLE;
            endcase
        end
    end
    assign indDone = indBusy && macRsp.ack;

    // data register: host value for writes, mac value for reads
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            indData_r <= `MHC_RST_ZERO32;
        else if (indDone && cmdDir_r)
            indData_r <= macRsp.rdata;
        else if (wrDone && paddr == `MHC_OFS_IND_DATA && !indBusy)
            indData_r <= strobeMerge(indData_r, pwdata, pstrb);
    end

    // request held as a level for the whole busy time
    assign macReq.valid = indBusy;
    assign macReq.read  = cmdDir_r;
    assign macReq.addr  = cmdAddr_r;
    assign macReq.wdata = indData_r;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // interrupts: sticky status, cleared by reading it, a new event in that cycle wins

    assign irqSet = {indDone, dropMidEvent};
    // status and mask
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irqStatus_r <= '0;
            irqMask_r   <= '0;
        end
        else
        begin
            // clear only what the read returned, so an event landing on the setup edge survives
            if (rdDone && paddr == `MHC_OFS_IRQ_STATUS)
                irqStatus_r <= (irqStatus_r & ~prdata_r[`MHC_IRQ_WIDTH-1:0]) | irqSet;
            else
                irqStatus_r <= irqStatus_r | irqSet;
            if (wrDone && paddr == `MHC_OFS_IRQ_MASK && pstrb[0])
                irqMask_r <= pwdata[`MHC_IRQ_WIDTH-1:0];
        end
    end
    assign irq = |(irqStatus_r & irqMask_r);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // the first edge after reset release still shows the reset value, hence the past-reset guard
    AST_TIMER_VIEW: assert property ($past(reset_n) |-> timerCount_r == $past(gpTimerCount))
        else $error("timer view does not follow timer count");
    AST_HALF_ORDER: assert property (hostUpperSel == (hostAddrBit1 ^ (halfOrder_r == `MHC_SWAP_PATTERN)))
        else $error("halfword select wrong for order setting");
    AST_TX_LOW_FIRST: assert property (txWordValid && txWordReady |=> txHalfValid && txHalf == $past(txWord[15:0])
                                       ##1 txHalfValid && txHalf == $past(txWord[31:16], 2))
        else $error("transmit halves out of order");
    AST_RX_LOW_FIRST: assert property (rxWordValid |-> rxWord[15:0] == $past(rxLow_r))
        else $error("receive word low half is not the first half");
    AST_FR_STEP: assert property (frTick && !softReset |=> freeRun_r == $past(freeRun_r) + 1'b1)
        else $error("free-run counter did not step");
    AST_FR_RATE: assert property (frTick ##1 !softReset [*4] |-> !frTick && !$past(frTick) && !$past(frTick, 2)
                                  && !$past(frTick, 3) ##1 frTick)
        else $error("free-run tick not every five cycles");
    AST_FR_CLEAR: assert property (softReset |=> freeRun_r == '0) else $error("free-run counter not cleared");
    AST_FR_SNAP: assert property (setupPhase && !pwrite && paddr == `MHC_OFS_FREE_RUN
                                  |=> freeRunHeld_r == prdata_r)
        else $error("snapshot differs from first read");
    AST_DROP_CLEAR: assert property (rdDone && paddr == `MHC_OFS_DROP_COUNT && !rxFrameDrop
                                     |=> dropCount_r == {31'h0000_0000, $past(rxFrameDrop, 2)})
        else $error("drop counter not cleared by read");
    AST_DROP_INC: assert property (rxFrameDrop && !(rdDone && paddr == `MHC_OFS_DROP_COUNT)
                                   |=> dropCount_r == $past(dropCount_r) + 32'h0000_0001)
        else $error("drop counter did not count");
    AST_DROP_MID: assert property (dropMidEvent |=> irqStatus_r[`MHC_IRQ_DROP_MID_BIT])
        else $error("midpoint event lost");
    AST_IND_START: assert property (!indBusy && wrDone && paddr == `MHC_OFS_IND_CMD && pstrb[3]
                                    && pwdata[`MHC_CMD_BUSY_BIT] |=> macReq.valid)
        else $error("indirect access did not start");
    AST_IND_DONE: assert property (indBusy && macRsp.ack && cmdDir_r
                                   |=> !indBusy && indData_r == $past(macRsp.rdata))
        else $error("busy or read data wrong after mac answer");
    AST_IND_HOLD: assert property (indBusy && !macRsp.ack |=> $stable(indData_r) && $stable(cmdAddr_r))
        else $error("indirect registers changed while busy");
    COV_IND_READ:  cover property (indBusy && cmdDir_r ##[1:20] !indBusy);
    COV_DROP_READ: cover property (rxFrameDrop ##[1:10] rdDone && paddr == `MHC_OFS_DROP_COUNT);
    COV_SWAPPED:   cover property (halfOrder_r == `MHC_SWAP_PATTERN && hostAddrBit1);
    COV_IRQ:       cover property (irq);
endmodule // mhc_csr_bank

// File: sim/mhc_mac_model.sv
// behavioural model of the internal mac register file behind the indirect window
`timescale 1ns/1ps

module mhc_mac_model #(
    parameter int LAT = 6
) (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire mhc_pkg::mhc_mac_req_t macReq,
    output mhc_pkg::mhc_mac_rsp_t      macRsp
);
    import mhc_pkg::*;
    logic [31:0] regs [256];
    int          waitCnt;
    ////////////////////////////////////////////////////////////////////////////////
    // slow answer so the busy bit is seen set; idle read data toggles instead of holding
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            macRsp  <= '0;
            waitCnt <= 0;
        end
        else
        begin
            macRsp.ack   <= 1'b0;
            macRsp.rdata <= ~macRsp.rdata;
            if (macReq.valid && !macRsp.ack)
            begin
                waitCnt <= (waitCnt == LAT) ? 0 : waitCnt + 1;
                if (waitCnt == LAT)
                begin
                    macRsp.ack <= 1'b1;
                    if (macReq.read)
                        macRsp.rdata <= regs[macReq.addr];
                    else
                        regs[macReq.addr] <= macReq.wdata;
                end
            end
        end
    end
endmodule // mhc_mac_model

// File: sim/mhc_csr_bank_bench.sv
// self-checking testbench of the misc host csr bank
`timescale 1ns/1ps
`include "mhc_csr_map.svh"

module mhc_csr_bank_bench;
    import mhc_pkg::*;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, err, softReset, hostAddrBit1, hostUpperSel;
    logic rxFrameDrop, txWordValid, txWordReady, txHalfValid, rxHalfValid, rxWordValid, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, txWord, rxWord, rd, snap;
    logic [15:0] gpTimerCount, txHalf, rxHalf;
    logic [3:0]  pstrb;
    logic [1:0]  powerState;
    mhc_mac_req_t macReq;
    mhc_mac_rsp_t macRsp;
    int errCount = 0;
    int checks = 0;

    mhc_csr_bank DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .gpTimerCount(gpTimerCount), .softReset(softReset), .powerState(powerState),
        .hostAddrBit1(hostAddrBit1), .hostUpperSel(hostUpperSel), .rxFrameDrop(rxFrameDrop),
        .txWordValid(txWordValid), .txWord(txWord), .txWordReady(txWordReady), .txHalfValid(txHalfValid),
        .txHalf(txHalf), .rxHalfValid(rxHalfValid), .rxHalf(rxHalf), .rxWordValid(rxWordValid),
        .rxWord(rxWord), .macReq(macReq), .macRsp(macRsp), .irq(irq));
    mhc_mac_model MAC (.clk(clk), .reset_n(reset_n), .macReq(macReq), .macRsp(macRsp));
    ////////////////////////////////////////////////////////////////////////////////
    // tasks: apb transfer, compare, bounded waits, verdict
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            $display("mismatch %0t got %h expected %h", $time, got, exp);
            errCount++;
        end
    endtask
    task automatic waitHigh(ref logic s);
        for (int i = 0; i < 4; i++)
        begin
            #1;
            if (s === 1'b1) return;
            @(posedge clk);
        end
        chk(s, 1);
    endtask
    // polling is bounded so a stuck busy bit cannot hang the run
    task automatic waitIdle();
        for (int i = 0; i < 30; i++)
        begin
            apb(0, `MHC_OFS_IND_CMD, 0);
            if (rd[`MHC_CMD_BUSY_BIT] === 1'b0) return;
        end
        chk(rd, 0);
    endtask
    task automatic testDone();
        if (errCount == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        errCount++;
        testDone();
    end
    ////////////////////////////////////////////////////////////////////////////////
    // test sequence
    initial
    begin
        {reset_n, psel, penable, pwrite, softReset, rxFrameDrop, txWordValid, rxHalfValid} = '0;
        {paddr, pwdata, txWord, rxHalf} = '0;
        {pstrb, gpTimerCount, hostAddrBit1, powerState} = {4'hF, 16'h1234, 1'b1, 2'h2};
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        apb(1, `MHC_OFS_TIMER_COUNT, 32'hFFFF_0000);
        apb(0, `MHC_OFS_TIMER_COUNT, 0); chk(rd, 32'h0000_1234);
        chk(hostUpperSel, 1);
        apb(1, `MHC_OFS_HALF_ORDER, `MHC_SWAP_PATTERN); #1 chk(hostUpperSel, 0);
        apb(1, `MHC_OFS_HALF_ORDER, 32'hFFFF_FFFE); #1 chk(hostUpperSel, 1);
        @(posedge clk) softReset <= 1'b1;
        @(posedge clk) softReset <= 1'b0;
        repeat (48) @(posedge clk);
        apb(0, `MHC_OFS_FREE_RUN, 0); chk(32'(rd inside {[8:12]}), 1);
        snap = rd;
        apb(0, `MHC_OFS_FREE_RUN_HELD, 0); chk(rd, snap);
        repeat (3) begin @(posedge clk) rxFrameDrop <= 1'b1; @(posedge clk) rxFrameDrop <= 1'b0; end
        apb(0, `MHC_OFS_DROP_COUNT, 0); chk(rd, 3);
        apb(0, `MHC_OFS_DROP_COUNT, 0); chk(rd, 0);
        // a drop counted on the read's setup edge is missing from that read and must survive its clear
        fork
            apb(0, `MHC_OFS_DROP_COUNT, 0);
            begin @(posedge clk) rxFrameDrop <= 1'b1; @(posedge clk) rxFrameDrop <= 1'b0; end
        join
        chk(rd, 0);
        apb(0, `MHC_OFS_DROP_COUNT, 0); chk(rd, 1);
        apb(0, 8'h04, 0); chk(rd, 0);
        chk(err, 1);
        apb(1, `MHC_OFS_IND_DATA, 32'hA5C3_0F96);
        apb(1, `MHC_OFS_IND_CMD, 32'h8000_3F12);
        apb(0, `MHC_OFS_IND_CMD, 0); chk(rd, 32'h8000_0012);
        waitIdle();
        apb(1, `MHC_OFS_IND_DATA, 0);
        apb(1, `MHC_OFS_IND_CMD, 32'hC000_0012);
        waitIdle();
        apb(0, `MHC_OFS_IND_DATA, 0); chk(rd, 32'hA5C3_0F96);
        chk(irq, 0);
        apb(1, `MHC_OFS_IRQ_MASK, 32'h0000_0002);
        @(posedge clk) #1 chk(irq, 1);
        apb(0, `MHC_OFS_IRQ_STATUS, 0); chk(rd, 32'h0000_0002);
        @(posedge clk) #1 chk(irq, 0);
        @(posedge clk) {txWordValid, txWord} <= {1'b1, 32'hBEEF_CAFE};
        @(posedge clk) txWordValid <= 1'b0;
        waitHigh(txHalfValid); chk(txHalf, 16'hCAFE);
        @(posedge clk) #1 chk({txHalfValid, txHalf}, 17'h1BEEF);
        @(posedge clk) {rxHalfValid, rxHalf} <= {1'b1, 16'h1111};
        @(posedge clk) rxHalf <= 16'h2222;
        @(posedge clk) {rxHalfValid, rxHalf} <= {1'b0, 16'hDDDD};
        waitHigh(rxWordValid); chk(rxWord, 32'h2222_1111);
        testDone();
    end
endmodule // mhc_csr_bank_bench
